//--- design/scc_top.sv
// Line sync edge select, clamp gating, coast hold and slicer threshold control
module scc_top
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Register port
  input  wire logic [scc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [scc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output wire logic [scc_pkg::DATA_W-1:0] reg_rdata_o,
  // Pins from the graphics source
  input  wire logic                       line_sync_i,
  input  wire logic                       ext_clamp_i,
  input  wire logic                       coast_i,
  input  wire logic                       embedded_sync_cmp_i,
  // To the clock generator and the clamp switches
  output wire logic                       line_ref_o,
  output wire logic                       pll_ref_o,
  output wire logic                       pll_hold_o,
  output wire logic                       clamp_o,
  // Slicer
  output wire logic [5:0]                 slice_thr_o,
  output wire logic                       sliced_sync_out_o
);

  scc_state_t        st_q;
  scc_state_t        st_d;
  scc_bus_req_t      req;
  logic [NUM_IN-1:0] pin_norm;
  logic [NUM_IN-1:0] pin_lvl;
  logic              sync_now;
  logic              trail;
  logic              ext_sel;
  logic              ext_act;
  logic              hold_act;

  // ==========================================================================
  // Pin polarity and synchronisation
  // ==========================================================================
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  // Polarity applied before the synchroniser so edges are always rising-leading
  always_comb
  begin
    pin_norm            = '0;
    pin_norm[IN_SYNC]   = line_sync_i ^ ~st_q.sync_ctrl[LINE_SYNC_SENSE_BIT];
    pin_norm[IN_CLAMP]  = ext_clamp_i ^ ~st_q.gate_ctrl[GATE_SENSE_BIT];
    pin_norm[IN_COAST]  = coast_i ^ ~st_q.gate_ctrl[HOLD_SENSE_BIT];
    pin_norm[IN_SLICED] = embedded_sync_cmp_i;
  end

  // Polarity flips mid-line may produce one spurious edge; software expects it
  scc_sync3 u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_norm),
    .level_o (pin_lvl)
  );

  // ==========================================================================
  // Derived levels and edges
  // ==========================================================================
  assign sync_now = pin_lvl[IN_SYNC];
  assign trail    = st_q.sync_prev & ~sync_now;
  assign ext_sel  = st_q.gate_ctrl[EXT_GATE_SEL_BIT];
  assign ext_act  = pin_lvl[IN_CLAMP];
  assign hold_act = pin_lvl[IN_COAST];

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    st_d           = st_q;
    st_d.sync_prev = sync_now;
    st_d.rdata     = '0;

    // Leading edge only; trailing edge never reaches the reference
    st_d.lead    = ~st_q.sync_prev & sync_now;
    // Reference withheld while coasting so the generator free-runs
    st_d.pll_ref = st_d.lead & ~hold_act;
    st_d.hold    = hold_act;
    st_d.sliced  = pin_lvl[IN_SLICED];

    // Register writes
    if (req.wr)
    begin
      case (req.addr)
        REG_SYNC_CTRL:   st_d.sync_ctrl = req.wdata;
        REG_GATE_CTRL:   st_d.gate_ctrl = req.wdata;
        REG_CLAMP_PLACE: st_d.place     = req.wdata;
        REG_CLAMP_DUR:   st_d.dur       = req.wdata;
        REG_SLICE_THR:
        begin
          // Codes past the top step saturate at 330 mV
          if (req.wdata[5:0] > SLICE_CODE_MAX || req.wdata[7:6] != 2'b00)
          begin
            st_d.thr = SLICE_CODE_MAX;
          end
          else
          begin
            st_d.thr = req.wdata[5:0];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Register reads, answered one cycle later; unmapped reads give zero
    if (req.rd)
    begin
      case (req.addr)
        REG_SYNC_CTRL:   st_d.rdata = st_q.sync_ctrl;
        REG_GATE_CTRL:   st_d.rdata = st_q.gate_ctrl;
        REG_CLAMP_PLACE: st_d.rdata = st_q.place;
        REG_CLAMP_DUR:   st_d.rdata = st_q.dur;
        REG_SLICE_THR:   st_d.rdata = {2'b00, st_q.thr};
        REG_STATUS:
        begin
          st_d.rdata[ST_CLAMP_BIT]  = st_q.clamp;
          st_d.rdata[ST_HOLD_BIT]   = st_q.hold;
          st_d.rdata[ST_SYNC_BIT]   = sync_now;
          st_d.rdata[ST_SLICED_BIT] = st_q.sliced;
        end
        default:         st_d.rdata = '0;
      endcase
    end

    // Internal clamp timer, restarted by each sync trailing edge
    case (st_q.ph)
      CLP_IDLE:
      begin
      end
      CLP_DELAY:
      begin
        st_d.cnt = st_q.cnt - 8'h01;
        if (st_q.cnt == 8'h01)
        begin
          st_d.ph  = CLP_ACTIVE;
          st_d.cnt = st_q.dur;
        end
      end
      CLP_ACTIVE:
      begin
        st_d.cnt = st_q.cnt - 8'h01;
        if (st_q.cnt == 8'h01)
        begin
          st_d.ph = CLP_IDLE;
        end
      end
      default:
      begin
        st_d.ph = CLP_IDLE;
      end
    endcase

    // Trailing edge wins over any count in progress
    if (trail)
    begin
      if (st_q.dur == 8'h00)
      begin
        st_d.ph = CLP_IDLE;
      end
      else if (st_q.place == 8'h00)
      begin
        st_d.ph  = CLP_ACTIVE;
        st_d.cnt = st_q.dur;
      end
      else
      begin
        st_d.ph  = CLP_DELAY;
        st_d.cnt = st_q.place;
      end
    end

    // Gate source: external pin only when selected, else the timer
    if (ext_sel)
    begin
      st_d.clamp = ext_act;
    end
    else
    begin
      st_d.clamp = (st_d.ph == CLP_ACTIVE);
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q           <= '0;
      st_q.sync_ctrl <= SYNC_CTRL_RST;
      st_q.gate_ctrl <= GATE_CTRL_RST;
      st_q.place     <= CLAMP_PLACE_RST;
      st_q.dur       <= CLAMP_DUR_RST;
      st_q.thr       <= SLICE_CODE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  // ==========================================================================
  assign reg_rdata_o       = st_q.rdata;
  assign line_ref_o        = st_q.lead;
  assign pll_ref_o         = st_q.pll_ref;
  assign pll_hold_o        = st_q.hold;
  assign clamp_o           = st_q.clamp;
  assign slice_thr_o       = st_q.thr;
  assign sliced_sync_out_o = st_q.sliced;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence trail_int_s;
    trail && !ext_sel && !req.wr && st_q.dur != 8'h00 && st_q.place != 8'h00;
  endsequence

  sequence delay_end_s;
    st_q.ph == CLP_DELAY && st_q.cnt == 8'h01 && !trail && !req.wr;
  endsequence

  lead_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_ref_o |=> !line_ref_o)
    else $error("line reference pulse longer than one cycle");

  lead_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_ref_o |-> $past(sync_now) && !$past(sync_now, 2))
    else $error("line reference not tied to a leading edge");

  coast_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pll_hold_o |-> !pll_ref_o)
    else $error("clock reference passed while coasting");

  ref_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_ref_o && !$past(hold_act) |-> pll_ref_o)
    else $error("clock reference missed outside coast");

  ext_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_sel && !req.wr |=> clamp_o == $past(ext_act))
    else $error("clamp does not follow external input");

  int_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ext_sel) && !$past(rst_i) |-> clamp_o == (st_q.ph == CLP_ACTIVE))
    else $error("internal clamp not from timer");

  clamp_place_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trail_int_s |=> st_q.ph == CLP_DELAY && st_q.cnt == $past(st_q.place))
    else $error("clamp delay not loaded from placement");

  clamp_dur_a: assert property (@(posedge clk_i) disable iff (rst_i)
    delay_end_s |=> st_q.ph == CLP_ACTIVE && st_q.cnt == $past(st_q.dur))
    else $error("clamp length not loaded from duration");

  thr_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    slice_thr_o <= SLICE_CODE_MAX)
    else $error("slicer threshold code out of range");

  sliced_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 sliced_sync_out_o == $past(pin_lvl[IN_SLICED]))
    else $error("sliced sync output inverted or late");

  // Pin senses: a set bit passes the pin straight, a clear bit inverts it
  sync_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_norm[IN_SYNC] == (st_q.sync_ctrl[LINE_SYNC_SENSE_BIT] ? line_sync_i : !line_sync_i))
    else $error("line sync sense not applied");

  gate_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_norm[IN_CLAMP] == (st_q.gate_ctrl[GATE_SENSE_BIT] ? ext_clamp_i : !ext_clamp_i))
    else $error("clamp input sense not applied");

  hold_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_norm[IN_COAST] == (st_q.gate_ctrl[HOLD_SENSE_BIT] ? coast_i : !coast_i))
    else $error("coast input sense not applied");

  trail_no_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trail |=> !line_ref_o)
    else $error("trailing sync edge gave a reference");

  hold_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_act |=> pll_hold_o)
    else $error("clock generator not held during coast");

  ext_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_sel && st_d.ph != CLP_ACTIVE |=> !clamp_o)
    else $error("clamp raised outside the timed interval");

  // Timer steps between trailing edges
  sequence clamp_last_s;
    st_q.ph == CLP_ACTIVE && st_q.cnt == 8'h01 && !trail;
  endsequence

  sequence delay_step_s;
    st_q.ph == CLP_DELAY && st_q.cnt != 8'h01 && !trail;
  endsequence

  clamp_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clamp_last_s |=> st_q.ph == CLP_IDLE)
    else $error("clamp outlasts its duration");

  delay_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    delay_step_s |=> st_q.ph == CLP_DELAY && st_q.cnt == $past(st_q.cnt) - 8'h01)
    else $error("clamp delay not counting down");

  dur_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trail && st_q.dur == 8'h00 |=> st_q.ph == CLP_IDLE)
    else $error("zero duration still started a clamp");

  rst_vals_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> slice_thr_o == SLICE_CODE_RST && !st_q.gate_ctrl[EXT_GATE_SEL_BIT]
      && st_q.gate_ctrl[HOLD_SENSE_BIT])
    else $error("reset defaults not in place");

  thr_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req.wr && req.addr == REG_SLICE_THR && req.wdata <= {2'b00, SLICE_CODE_MAX}
      |=> slice_thr_o == $past(req.wdata[5:0]))
    else $error("slicer threshold code not taken");

  thr_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req.wr && req.addr == REG_SLICE_THR && req.wdata > {2'b00, SLICE_CODE_MAX}
      |=> slice_thr_o == SLICE_CODE_MAX)
    else $error("slicer threshold code not saturated");

endmodule : scc_top

//--- shared/scc_pkg.sv
// Package: constants, types and register map of the sync, clamp and coast control block
package scc_pkg;

  // ==========================================================================
  // Register bus geometry
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] REG_CLAMP_PLACE = 8'h05;  // Clamp delay after sync trailing edge
  localparam logic [7:0] REG_CLAMP_DUR   = 8'h06;  // Clamp length in pixel periods
  localparam logic [7:0] REG_SLICE_THR   = 8'h07;  // Embedded sync slicer threshold code
  localparam logic [7:0] REG_STATUS      = 8'h08;  // Read-only live state
  localparam logic [7:0] REG_SYNC_CTRL   = 8'h0E;  // Line sync control
  localparam logic [7:0] REG_GATE_CTRL   = 8'h0F;  // Clamp and coast control

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned LINE_SYNC_SENSE_BIT = 6;  // In REG_SYNC_CTRL
  localparam int unsigned EXT_GATE_SEL_BIT    = 7;  // In REG_GATE_CTRL
  localparam int unsigned GATE_SENSE_BIT      = 6;  // In REG_GATE_CTRL
  localparam int unsigned HOLD_SENSE_BIT      = 3;  // In REG_GATE_CTRL
  localparam int unsigned ST_CLAMP_BIT        = 0;  // In REG_STATUS
  localparam int unsigned ST_HOLD_BIT         = 1;
  localparam int unsigned ST_SYNC_BIT         = 2;
  localparam int unsigned ST_SLICED_BIT       = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] SYNC_CTRL_RST   = 8'h40;  // Rising edge active
  localparam logic [7:0] GATE_CTRL_RST   = 8'h48;  // Internal clamp, active-high gate, hold high
  localparam logic [7:0] CLAMP_PLACE_RST = 8'h09;
  localparam logic [7:0] CLAMP_DUR_RST   = 8'h14;

  // ==========================================================================
  // Slicer threshold: code n means (n + 1) steps above the negative peak
  // ==========================================================================
  localparam int unsigned SLICE_STEP_MV  = 10;
  localparam int unsigned SLICE_MIN_MV   = 10;
  localparam int unsigned SLICE_MAX_MV   = 330;
  localparam int unsigned SLICE_DEF_MV   = 150;
  localparam logic [5:0]  SLICE_CODE_MAX = 6'((SLICE_MAX_MV - SLICE_MIN_MV) / SLICE_STEP_MV);
  localparam logic [5:0]  SLICE_CODE_RST = 6'((SLICE_DEF_MV - SLICE_MIN_MV) / SLICE_STEP_MV);

  // ==========================================================================
  // Input synchroniser lanes
  // ==========================================================================
  localparam int unsigned NUM_IN    = 4;
  localparam int unsigned IN_SYNC   = 0;
  localparam int unsigned IN_CLAMP  = 1;
  localparam int unsigned IN_COAST  = 2;
  localparam int unsigned IN_SLICED = 3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    CLP_IDLE,
    CLP_DELAY,
    CLP_ACTIVE
  } scc_clp_ph_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } scc_bus_req_t;

  typedef struct packed {
    logic [NUM_IN-1:0] f1;
    logic [NUM_IN-1:0] f2;
    logic [NUM_IN-1:0] f3;
    logic [NUM_IN-1:0] lvl;
  } scc_sync_st_t;

  typedef struct packed {
    logic [7:0]  sync_ctrl;
    logic [7:0]  gate_ctrl;
    logic [7:0]  place;
    logic [7:0]  dur;
    logic [5:0]  thr;
    logic [7:0]  rdata;
    scc_clp_ph_t ph;
    logic [7:0]  cnt;
    logic        sync_prev;
    logic        lead;
    logic        pll_ref;
    logic        hold;
    logic        clamp;
    logic        sliced;
  } scc_state_t;

endpackage : scc_pkg

//--- design/scc_sync3.sv
// Three-stage input synchroniser with agreement filter for asynchronous pins
module scc_sync3
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Asynchronous inputs and filtered levels
  input  wire logic [scc_pkg::NUM_IN-1:0] async_i,
  output wire logic [scc_pkg::NUM_IN-1:0] level_o
);

  scc_sync_st_t st_q;
  scc_sync_st_t st_d;

  // ==========================================================================
  // Next state: first stage only feeds the second
  // ==========================================================================
  always_comb
  begin
    st_d    = st_q;
    st_d.f1 = async_i;
    st_d.f2 = st_q.f1;
    st_d.f3 = st_q.f2;
    // A change counts only once stages two and three agree
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (st_q.f2[i] == st_q.f3[i])
      begin
        st_d.lvl[i] = st_q.f3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;

endmodule : scc_sync3

//--- verif/scc_src_model.sv
// Graphics source model driving the sync, clamp, coast and comparator pins
module scc_src_model
(
  // Clock
  input  wire logic clk_i,
  // Pins towards the digitizer
  output logic      line_sync_o,
  output logic      ext_clamp_o,
  output logic      coast_o,
  output logic      cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle levels
  // ==========================================================================
  // Unused pins sit at the level that never asserts
  initial
  begin
    line_sync_o = 1'b0;
    ext_clamp_o = 1'b0;  // Grounded clamp
    coast_o     = 1'b0;  // Grounded coast with hold sense 1
    cmp_o       = 1'b0;
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Change one pin just after a clock edge
  task automatic set_pin(input int which, input logic lvl);
    @(posedge clk_i);
    case (which)
      0:       line_sync_o <= lvl;
      1:       ext_clamp_o <= lvl;
      2:       coast_o     <= lvl;
      default: cmp_o       <= lvl;
    endcase
  endtask : set_pin

  // Pulse for width cycles; under 2 the filter would eat it
  task automatic pulse(input int which, input logic lvl, input int width);
    set_pin(which, lvl);
    repeat (width - 1) @(posedge clk_i);
    set_pin(which, !lvl);
  endtask : pulse
endmodule : scc_src_model

//--- verif/tb_top.sv
// Self-checking bench for the sync, clamp and coast control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;

  // ==========================================================================
  // Signals and scoreboard
  // ==========================================================================
  logic       clk_i, rst_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pl, du, w;
  logic       line_sync_i, ext_clamp_i, coast_i, cmp_i;
  logic       line_ref_o, pll_ref_o, pll_hold_o, clamp_o, sliced_o;
  logic [5:0] slice_thr_o;
  logic [7:0] exp_q[$];
  logic [7:0] codes[5];
  int         error_cnt = 0, n_tests = 0, cyc = 0, r0, p0, c0, d, a;
  int         n_ref = 0, n_pll = 0, n_clp = 0, clp_len = 0, ref_cyc = 0, rise_cyc = 0;
  logic       rd_seen = 1'b0, clp_prev = 1'b0;

  // Free-running pixel clock and cycle count
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // ==========================================================================
  // Design and source model
  // ==========================================================================
  scc_top uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .line_sync_i(line_sync_i), .ext_clamp_i(ext_clamp_i),
    .coast_i(coast_i), .embedded_sync_cmp_i(cmp_i), .line_ref_o(line_ref_o),
    .pll_ref_o(pll_ref_o), .pll_hold_o(pll_hold_o), .clamp_o(clamp_o),
    .slice_thr_o(slice_thr_o), .sliced_sync_out_o(sliced_o));
  scc_src_model src (.clk_i(clk_i), .line_sync_o(line_sync_i), .ext_clamp_o(ext_clamp_i),
    .coast_o(coast_i), .cmp_o(cmp_i));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // One-cycle strobes; the slave never stalls
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= addr;
    reg_wdata_i <= data;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // Expected data is queued; the monitor compares it a cycle later
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= addr;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
  endtask : rd

  // ==========================================================================
  // Output monitor
  // ==========================================================================
  // Sampled mid-cycle so edge updates have landed; pulses counted per cycle
  always @(negedge clk_i)
  begin
    if (rd_seen && exp_q.size() > 0)
      chk(reg_rdata_o, exp_q.pop_front());
    rd_seen = reg_rd_i;
    if (line_ref_o === 1'b1)
    begin
      n_ref++;
      ref_cyc = cyc;
    end
    if (pll_ref_o === 1'b1)
      n_pll++;
    if (clamp_o === 1'b1 && !clp_prev)
    begin
      n_clp++;
      rise_cyc = cyc;
    end
    clp_len  = (clamp_o === 1'b1) ? (clp_prev ? clp_len + 1 : 1) : clp_len;
    clp_prev = (clamp_o === 1'b1);
  end

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(70563));
    rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
    idle(2);
    rst_i <= 1'b0;
    chk({2'b00, slice_thr_o}, 8'h0E);
    idle(6);
    rd(REG_SYNC_CTRL, 8'h40);
    rd(REG_GATE_CTRL, 8'h48);
    rd(REG_CLAMP_PLACE, 8'h09);
    rd(REG_CLAMP_DUR, 8'h14);
    rd(REG_SLICE_THR, 8'h0E);
    wr(REG_STATUS, 8'hFF);
    rd(REG_STATUS, 8'h00);
    rd(8'h20, 8'h00);
    $display("test reset done");
    // Both edge senses; trailing edge must give nothing
    for (int s = 0; s < 2; s++)
    begin
      src.set_pin(0, !s[0]);
      wr(REG_SYNC_CTRL, s[0] ? 8'h40 : 8'h00);
      idle(10);
      r0 = n_ref;
      p0 = n_pll;
      src.pulse(0, s[0], 8);
      idle(10);
      chk(8'(n_ref - r0), 8'h01);
      chk(8'(n_pll - p0), 8'h01);
    end
    $display("test edge done");
    // Coast in both senses stops the reference reaching the generator
    for (int h = 0; h < 2; h++)
    begin
      src.set_pin(2, !h[0]);
      wr(REG_GATE_CTRL, h[0] ? 8'h48 : 8'h40);
      idle(8);
      chk({7'h00, pll_hold_o}, 8'h00);
      src.set_pin(2, h[0]);
      idle(8);
      chk({7'h00, pll_hold_o}, 8'h01);
      r0 = n_ref;
      p0 = n_pll;
      src.pulse(0, 1'b1, 6);
      idle(10);
      chk(8'(n_ref - r0), 8'h01);
      chk(8'(n_pll - p0), 8'h00);
      src.set_pin(2, !h[0]);
      idle(8);
      chk({7'h00, pll_hold_o}, 8'h00);
    end
    $display("test coast done");
    // Clamp pin ignored without external gating
    c0 = n_clp;
    src.set_pin(1, 1'b1);
    idle(20);
    chk(8'(n_clp - c0), 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      pl = (k == 1) ? 8'h00 : (k == 2) ? 8'hFF : 8'($urandom_range(1, 20));
      du = (k == 0) ? 8'h00 : (k == 3) ? 8'hFF : 8'($urandom_range(1, 30));
      wr(REG_CLAMP_PLACE, pl);
      wr(REG_CLAMP_DUR, du);
      c0 = n_clp;
      src.pulse(0, 1'b1, 6);
      idle(int'(pl) + int'(du) + 30);
      chk(8'(n_clp - c0), {7'h00, du != 8'h00});
      if (du != 8'h00)
      begin
        // Filter latency cancels: rise trails the lead by pulse width plus placement
        d = rise_cyc - ref_cyc;
        a = d - int'(pl);
        chk(8'(clp_len), du);
        chk(8'(a), 8'h06);
      end
    end
    src.set_pin(1, 1'b0);
    $display("test internal clamp done");
    // External gating in both clamp senses
    for (int g = 0; g < 2; g++)
    begin
      wr(REG_GATE_CTRL, g[0] ? 8'h48 : 8'h08);
      src.set_pin(1, !g[0]);
      idle(8);
      wr(REG_GATE_CTRL, g[0] ? 8'hC8 : 8'h88);
      idle(4);
      w = 8'($urandom_range(3, 12));
      c0 = n_clp;
      src.pulse(1, g[0], int'(w));
      idle(12);
      chk(8'(n_clp - c0), 8'h01);
      chk(8'(clp_len), w);
    end
    $display("test external clamp done");
    // Threshold codes, with saturation above the top step
    codes = '{8'h00, 8'($urandom_range(1, 31)), 8'h20, 8'h21, 8'hC5};
    foreach (codes[i])
    begin
      wr(REG_SLICE_THR, codes[i]);
      idle(2);
      chk({2'b00, slice_thr_o}, (codes[i] > 8'h20) ? 8'h20 : codes[i]);
    end
    src.set_pin(3, 1'b1);
    idle(8);
    chk({7'h00, sliced_o}, 8'h01);
    rd(REG_STATUS, 8'h08);
    src.set_pin(3, 1'b0);
    idle(8);
    chk({7'h00, sliced_o}, 8'h00);
    $display("test slicer done");
    idle(4);
    finish_test();
  end
endmodule : tb_top
